// File: verilog/rpeq_pkg.sv
// Purpose: Shared constants for the rotor position event qualifier.
// Assumes: 250 MHz mclk, AHB-Lite register access with 32-bit words.
// Notes:   Contract
// Contract
// R1 - Sensor mode select bit chooses mode
// R2 - Sensor mode uses logic levels on inputs
// R3 - Input select routes one input
// R4 - Sensor mode disables all demagnetization handling
// R5 - Sensor mode accepts Z in any window
// R6 - Sensor mode samples at 800 kHz
// R7 - Sensor mode minimum off time 1.25 us
// R8 - Direct access freezes the latched sample
// R9 - Software relatches by clearing then setting bit
// R10 - Latched input readable in mask register
// R11 - Sensorless: D on tick, no D 20us after C
// R12 - Sensorless: no Z 20us after D, both behaviours
// R13 - Sensor: ignore bit2, no Z 20us after C
// R14 - Current mode group permission table
// R15 - Voltage mode group permission table
// R16 - Both groups config permits either group
// R17 - Sensor mode always permits, else forbidden
// R18 - Sensorless events strictly in C, D, Z order
// R19 - Z sets flag, request when masked in
// R20 - Position inputs pass a synchronizer
package rpeq_pkg;

	localparam logic [7:0]  ADDR_CTRL_A      = 8'h00;
	localparam logic [7:0]  ADDR_PHASE       = 8'h04;
	localparam logic [7:0]  ADDR_CONFIG      = 8'h08;
	localparam logic [7:0]  ADDR_MASK        = 8'h0C;
	localparam logic [7:0]  ADDR_STATUS      = 8'h10;

	localparam int          CTRL_SENSOR_BIT  = 0;
	localparam int          CTRL_DIRECT_BIT  = 1;
	localparam int          PHASE_SEL_LSB    = 0;
	localparam int          CFG_OS_LSB       = 0;
	localparam int          CFG_VC_BIT       = 3;
	localparam int          CFG_REO_BIT      = 4;
	localparam int          CFG_ZLEVEL_BIT   = 5;
	localparam int          CFG_DLEVEL_BIT   = 6;
	localparam int          CFG_HWD_BIT      = 7;
	localparam int          CFG_SWD_BIT      = 8;
	localparam int          CFG_OT_LSB       = 12;
	localparam int          MASK_Z_BIT       = 0;
	localparam int          MASK_D_BIT       = 1;
	localparam int          MASK_STATE_BIT   = 7;
	localparam int          STAT_Z_BIT       = 0;
	localparam int          STAT_D_BIT       = 1;
	localparam int          STAT_C_BIT       = 2;

	localparam logic [1:0]  CTRL_RESET       = 2'h0;
	localparam logic [1:0]  PHASE_RESET      = 2'h0;
	localparam logic [15:0] CONFIG_RESET     = 16'h0000;
	localparam logic [1:0]  MASK_RESET       = 2'h0;

	localparam int          CLK_PERIOD_NS    = 4;
	localparam int          SAMPLE_PERIOD_NS = 1250;
	localparam int          SAMPLE_CYC       = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int          MIN_OFF_NS       = 1250;
	localparam int          MIN_OFF_CYC      = (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          FILTER_US        = 20;
	localparam int          FILTER_CYC       = (FILTER_US * 1000 + CLK_PERIOD_NS - 1)
	                                           / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		WAIT_C,
		WAIT_D,
		WAIT_Z
	} rpeq_step_e;

endpackage : rpeq_pkg

// File: verilog/rpeq_sync3.sv
// Purpose: Three-stage synchronizer with agreement filter, one per bit.
// Assumes: Inputs are asynchronous to mclk.
// Notes:   The output moves only when the second and third stages agree.
`timescale 1ns/1ns
module rpeq_sync3 #(
	parameter int WIDTH = 4
) (
	input  wire logic             mclk,
	input  wire logic             rst_b,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic s1;
			logic s2;
			logic s3;
			always_ff @(posedge mclk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					s1          <= 1'b0;
					s2          <= 1'b0;
					s3          <= 1'b0;
					sync_out[i] <= 1'b0;
				end
				else if (ce)
				begin
					s1 <= async_in[i];
					s2 <= s1;
					s3 <= s2;
					// A single glitch sample on the second stage is not taken.
					if (s2 == s3)
						sync_out[i] <= s3; // R20
				end
			end
		end
	endgenerate
endmodule : rpeq_sync3

// File: verilog/rpeq_qualifier.sv
// Purpose: Rotor position detection front end with C, D, Z qualification.
// Assumes: Commutation, soft demagnetization and window strobes come from mclk logic.
// Notes:   Registers on AHB-Lite; reads take one wait state, writes none.
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
module rpeq_qualifier
	import rpeq_pkg::*;
#(
	parameter int unsigned FILTER_CYCLES = FILTER_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        position_input_a,
	input  wire logic        position_input_b,
	input  wire logic        position_input_c,
	input  wire logic        comparator_out,
	input  wire logic        commutation_evt,
	input  wire logic        soft_demag_evt,
	input  wire logic        window_sample_strobe,
	input  wire logic        pwm_on_odd_group,
	output logic             zero_cross_evt,
	output logic             demag_evt,
	output logic             zero_cross_irq,
	output logic             bemf_read_ok,
	output logic             pwm_after_demag,
	output logic      [2:0]  output_config_eff,
	output logic      [8:0]  min_off_cycles
);
	logic [1:0]  control_reg_a;
	logic [1:0]  phase_state_reg;
	logic [15:0] config_reg;
	logic [1:0]  interrupt_mask_reg;
	logic        zero_cross_flag;
	logic        demag_flag;
	logic        commut_flag;
	logic        sampled_input_state;
	logic [3:0]  sync_in;
	logic [3:0]  sync_q;
	logic [8:0]  tick_cnt;
	logic        sample_tick;
	logic [12:0] filter_cnt;
	logic        filter_done;
	logic        selected_in;
	logic        sensor_mode_sel;
	logic        direct_access;
	logic [1:0]  input_select;
	logic [2:0]  output_config;
	logic        voltage_current_sel;
	logic        read_group_sel;
	logic [3:0]  off_time_setting;
	logic        accept_c;
	logic        accept_d;
	logic        accept_z;
	logic        mode_write;
	logic        dp_write;
	logic        dp_wait;
	logic [7:0]  dp_addr;
	logic        addr_ok;
	logic        wr_en;
	logic [31:0] read_word;
	rpeq_step_e  step;

	assign sensor_mode_sel     = control_reg_a[CTRL_SENSOR_BIT];
	assign direct_access       = control_reg_a[CTRL_DIRECT_BIT];
	assign input_select        = phase_state_reg;
	assign output_config       = config_reg[CFG_OS_LSB +: 3];
	assign voltage_current_sel = config_reg[CFG_VC_BIT];
	assign read_group_sel      = config_reg[CFG_REO_BIT];
	assign off_time_setting    = config_reg[CFG_OT_LSB +: 4];

	// Bus side.
	assign addr_ok   = hsel && htrans[1] && hready;
	assign wr_en     = dp_write && hready && ce;
	assign hreadyout = !dp_wait;
	assign hresp     = 1'b0;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dp_write <= 1'b0;
			dp_wait  <= 1'b0;
			dp_addr  <= 8'h00;
		end
		else if (ce)
		begin
			if (dp_wait)
				dp_wait <= 1'b0;
			else if (hready)
			begin
				dp_write <= addr_ok && hwrite;
				dp_wait  <= addr_ok && !hwrite;
				if (addr_ok)
					dp_addr <= {haddr[7:2], 2'b00};
			end
		end
	end

	always_comb
	begin
		read_word = 32'h0000_0000;
		case (dp_addr)
			ADDR_CTRL_A:
				read_word[1:0] = control_reg_a;
			ADDR_PHASE:
				read_word[1:0] = phase_state_reg;
			ADDR_CONFIG:
				read_word[15:0] = config_reg;
			ADDR_MASK:
			begin
				read_word[MASK_Z_BIT]     = interrupt_mask_reg[MASK_Z_BIT];
				read_word[MASK_D_BIT]     = interrupt_mask_reg[MASK_D_BIT];
				read_word[MASK_STATE_BIT] = sampled_input_state; // R10
			end
			ADDR_STATUS:
			begin
				read_word[STAT_Z_BIT] = zero_cross_flag;
				read_word[STAT_D_BIT] = demag_flag;
				read_word[STAT_C_BIT] = commut_flag;
			end
			default:
				read_word = 32'h0000_0000;
		endcase
	end

	// The wait state lets a read see a write taken in the cycle before it.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			hrdata <= 32'h0000_0000;
		else if (ce && dp_wait)
			hrdata <= read_word;
	end

	assign mode_write = wr_en && (dp_addr == ADDR_CTRL_A)
	                    && (hwdata[CTRL_SENSOR_BIT] != sensor_mode_sel);

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			control_reg_a      <= CTRL_RESET;
			phase_state_reg    <= PHASE_RESET;
			config_reg         <= CONFIG_RESET;
			interrupt_mask_reg <= MASK_RESET;
		end
		else if (wr_en)
		begin
			case (dp_addr)
				ADDR_CTRL_A:
					control_reg_a <= hwdata[1:0]; // R1
				ADDR_PHASE:
					phase_state_reg <= hwdata[PHASE_SEL_LSB +: 2];
				ADDR_CONFIG:
					config_reg <= hwdata[15:0];
				ADDR_MASK:
					interrupt_mask_reg <= hwdata[1:0];
				default:
					control_reg_a <= control_reg_a;
			endcase
		end
	end

	// Input stage.
	assign sync_in = {comparator_out, position_input_c, position_input_b, position_input_a};

	rpeq_sync3 #(
		.WIDTH    (4)
	) u_sync (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.ce       (ce),
		.async_in (sync_in),
		.sync_out (sync_q)
	);

	always_comb
	begin
		selected_in = 1'b0;
		if (!sensor_mode_sel)
			selected_in = sync_q[3];
		else
		begin
			case (input_select) // R3
				2'h0:    selected_in = sync_q[0]; // R2
				2'h1:    selected_in = sync_q[1];
				2'h2:    selected_in = sync_q[2];
				default: selected_in = 1'b0;
			endcase
		end
	end

	// Direct access stands for the stopped peripheral clock: the tick halts.
	assign sample_tick = (tick_cnt == 9'(SAMPLE_CYC - 1)) && !direct_access; // R8

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			tick_cnt <= 9'h000;
		else if (ce && !direct_access)
			tick_cnt <= sample_tick ? 9'h000 : tick_cnt + 9'h001; // R6
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			sampled_input_state <= 1'b0;
		else if (ce && sample_tick)
			sampled_input_state <= selected_in; // R8
	end

	// Back-EMF read permission.
	always_comb
	begin
		bemf_read_ok = 1'b0;
		if (sensor_mode_sel)
			bemf_read_ok = 1'b1; // R17
		else if (output_config[1:0] == 2'b11)
			bemf_read_ok = 1'b1; // R16
		else if (voltage_current_sel)
		begin
			case (output_config[1:0]) // R14
				2'b00:   bemf_read_ok = !read_group_sel;
				2'b01:   bemf_read_ok = read_group_sel;
				2'b10:   bemf_read_ok = read_group_sel == pwm_on_odd_group;
				default: bemf_read_ok = 1'b0;
			endcase
		end
		else
		begin
			case (output_config) // R15
				3'b000, 3'b100: bemf_read_ok = !read_group_sel;
				3'b001, 3'b101: bemf_read_ok = read_group_sel;
				3'b110:         bemf_read_ok = read_group_sel == pwm_on_odd_group;
				default:        bemf_read_ok = 1'b0; // R17
			endcase
		end
	end

	// Event qualification; sensorless Z is read at the PWM window, sensor Z at the tick.
	assign filter_done = filter_cnt == 13'h0000;
	assign accept_c    = commutation_evt && step == WAIT_C;
	assign accept_d    = !sensor_mode_sel && step == WAIT_D && filter_done // R4 R11
	                     && ((config_reg[CFG_SWD_BIT] && soft_demag_evt)
	                     || (config_reg[CFG_HWD_BIT] && sample_tick
	                     && selected_in == config_reg[CFG_DLEVEL_BIT]));
	assign accept_z    = step == WAIT_Z && filter_done && bemf_read_ok // R12 R13
	                     && (sensor_mode_sel
	                     ? (sample_tick && selected_in == config_reg[CFG_ZLEVEL_BIT]) // R5
	                     : (window_sample_strobe
	                     && selected_in == config_reg[CFG_ZLEVEL_BIT]));

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			step <= WAIT_C;
		else if (ce)
		begin
			if (mode_write)
				step <= WAIT_C;
			else
			begin
				case (step) // R18
					WAIT_C:
						if (accept_c)
							step <= sensor_mode_sel ? WAIT_Z : WAIT_D; // R4
					WAIT_D:
						if (accept_d)
							step <= WAIT_Z;
					WAIT_Z:
						if (accept_z)
							step <= WAIT_C;
					default:
						step <= WAIT_C;
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			filter_cnt <= 13'h0000;
		else if (ce)
		begin
			if (accept_c || accept_d)
				filter_cnt <= 13'(FILTER_CYCLES); // R11 R12 R13
			else if (!filter_done)
				filter_cnt <= filter_cnt - 13'h0001;
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			zero_cross_evt <= 1'b0;
			demag_evt      <= 1'b0;
		end
		else if (ce)
		begin
			zero_cross_evt <= accept_z;
			demag_evt      <= accept_d;
		end
	end

	// Sticky flags: a new event wins over a write-one clear in the same cycle.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			zero_cross_flag <= 1'b0;
			demag_flag      <= 1'b0;
			commut_flag     <= 1'b0;
		end
		else if (ce)
		begin
			if (accept_z)
				zero_cross_flag <= 1'b1; // R19
			else if (wr_en && dp_addr == ADDR_STATUS && hwdata[STAT_Z_BIT])
				zero_cross_flag <= 1'b0;
			if (accept_d)
				demag_flag <= 1'b1;
			else if (wr_en && dp_addr == ADDR_STATUS && hwdata[STAT_D_BIT])
				demag_flag <= 1'b0;
			if (accept_c)
				commut_flag <= 1'b1;
			else if (wr_en && dp_addr == ADDR_STATUS && hwdata[STAT_C_BIT])
				commut_flag <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			zero_cross_irq <= 1'b0;
		else if (ce)
			zero_cross_irq <= (zero_cross_flag && interrupt_mask_reg[MASK_Z_BIT]) // R19
			                  || (demag_flag && interrupt_mask_reg[MASK_D_BIT]);
	end

	// PWM-facing configuration.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pwm_after_demag   <= 1'b0;
			output_config_eff <= 3'h0;
			min_off_cycles    <= 9'h000;
		end
		else if (ce)
		begin
			pwm_after_demag   <= sensor_mode_sel || step == WAIT_Z; // R12 R13
			output_config_eff <= {output_config[2] && !sensor_mode_sel, // R13
			                      output_config[1:0]};
			min_off_cycles    <= sensor_mode_sel ? 9'(MIN_OFF_CYC) // R7
			                     : 9'({5'h00, off_time_setting} * 9'(MIN_OFF_CYC));
		end
	end

endmodule : rpeq_qualifier

// File: tb/rpeq_sensor_model.sv
// Purpose: Rotor sensors and phase comparator seen by the qualifier.
// Assumes: The bench sets the wanted level of each of the four lines.
// Notes:   A 1 ns lag keeps sensor edges off the clock edge, as real ones are.
`timescale 1ns/1ns
module rpeq_sensor_model (
	input  wire logic [3:0] level,
	output logic            position_input_a,
	output logic            position_input_b,
	output logic            position_input_c,
	output logic            comparator_out
);
	// Steady logic levels only, never analog values.
	assign #1 {comparator_out, position_input_c, position_input_b, position_input_a} = level;
endmodule : rpeq_sensor_model

// File: tb/rpeq_checker.sv
// Purpose: Port assertions for the rotor position event qualifier.
// Assumes: One mclk domain.
// Notes:   D-to-Z spacing uses a saturating counter, not a long repetition.
`timescale 1ns/1ns
module rpeq_checker #(
	parameter int unsigned FILTER_CYCLES = 20
) (
	input wire logic       mclk,
	input wire logic       rst_b,
	input wire logic       ce,
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hready,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       zero_cross_evt,
	input wire logic       demag_evt,
	input wire logic       zero_cross_irq,
	input wire logic       bemf_read_ok,
	input wire logic       pwm_after_demag
);
	logic [15:0] since_d;
	logic        take;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	assign take = hsel && htrans[1] && hready && ce;

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			since_d <= 16'hFFFF;
		else if (demag_evt)
			since_d <= 16'h0000;
		else if (since_d != 16'hFFFF)
			since_d <= since_d + 16'h0001;
	end

	chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read lacks its single wait state");
	chk_write_fast: assert property (take && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	chk_z_gate: assert property (zero_cross_evt |-> $past(bemf_read_ok) && $past(pwm_after_demag))
		else $error("zero crossing taken while reading forbidden");
	chk_z_single: assert property (zero_cross_evt |=> !zero_cross_evt)
		else $error("zero crossing repeated without commutation");
	chk_d_step: assert property (demag_evt |-> !pwm_after_demag ##1 pwm_after_demag)
		else $error("demagnetization out of step");
	chk_z_filter: assert property (zero_cross_evt |-> since_d >= 16'(FILTER_CYCLES - 1))
		else $error("zero crossing inside filter after demagnetization");
	chk_irq_cause: assert property ($rose(zero_cross_irq) |-> $past(zero_cross_evt || demag_evt))
		else $error("interrupt without event");
endmodule : rpeq_checker

bind rpeq_qualifier rpeq_checker #(.FILTER_CYCLES(FILTER_CYCLES)) u_chk (
	.mclk(mclk), .rst_b(rst_b), .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .zero_cross_evt(zero_cross_evt),
	.demag_evt(demag_evt), .zero_cross_irq(zero_cross_irq), .bemf_read_ok(bemf_read_ok),
	.pwm_after_demag(pwm_after_demag));

// File: tb/rotor_position_event_qualifier_tb_top.sv
// Purpose: Self-checking bench for the rotor position event qualifier.
// Assumes: FILTER_CYCLES shortened to 20; ce is lowered once, with the bus idle.
// Notes:   Waits of 700 cycles span two fixed 312-cycle sample ticks.
`timescale 1ns/1ns
module rotor_position_event_qualifier_tb_top import rpeq_pkg::*;;
	logic        mclk, rst_b, hsel, hwrite, pwm_odd, irq, bemf, hro, hresp, ce;
	logic        zev, dev, pa, pb, pc, cmp, pad;
	logic [1:0]  htrans;
	logic [2:0]  ev, os_eff;
	logic [3:0]  lvl;
	logic [8:0]  moff;
	logic [31:0] haddr, hwdata, hrdata;
	int          err_count, checks_done, nz, nd, bz, bd, i, s;

	rpeq_sensor_model sens (.level(lvl), .position_input_a(pa), .position_input_b(pb),
		.position_input_c(pc), .comparator_out(cmp));
	rpeq_qualifier #(.FILTER_CYCLES(20)) dut (.mclk(mclk), .rst_b(rst_b), .ce(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hro), .hrdata(hrdata), .hreadyout(hro), .hresp(hresp),
		.position_input_a(pa), .position_input_b(pb), .position_input_c(pc),
		.comparator_out(cmp), .commutation_evt(ev[0]), .soft_demag_evt(ev[1]),
		.window_sample_strobe(ev[2]), .pwm_on_odd_group(pwm_odd), .zero_cross_evt(zev),
		.demag_evt(dev), .zero_cross_irq(irq), .bemf_read_ok(bemf),
		.pwm_after_demag(pad), .output_config_eff(os_eff), .min_off_cycles(moff));

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	always @(negedge mclk)
	begin
		if (zev === 1'b1)
			nz++;
		if (dev === 1'b1)
			nd++;
	end

	task automatic results;
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wait_rdy;
		int n;
		for (n = 0; n < 100; n++)
		begin
			@(negedge mclk);
			if (hro === 1'b1)
				return;
		end
		err_count++;
		results();
	endtask : wait_rdy

	// Address phase is held until ready, then data phase until ready again.
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		@(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		@(posedge mclk);
		r = hrdata;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(a, 1'b1, d, r);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] r;
		xfer(a, 1'b0, 32'h00000000, r);
		chk(nm, e, r);
	endtask : rdc

	// The task ends one edge after lowering, so back-to-back calls never clash.
	task automatic pulse(input logic [2:0] e);
		ev <= e;
		@(posedge mclk);
		ev <= 3'h0;
		@(posedge mclk);
	endtask : pulse

	task automatic wait_n(ref int c, input int t);
		int n;
		for (n = 0; n < 1000 && c < t; n++)
			@(negedge mclk);
		if (c < t)
		begin
			err_count++;
			results();
		end
		@(posedge mclk);
	endtask : wait_n

	// Bits 2:0 output config, 3 current mode, 4 odd read group, 5 PWM on odd.
	function automatic logic ok_exp(input logic sm, input logic [5:0] c);
		if (sm || c[1:0] == 2'h3)
			return 1'b1;
		if (c[1:0] == 2'h2)
			return (c[3] || c[2]) && c[4] == c[5];
		return c[4] == c[0];
	endfunction : ok_exp

	initial
	begin
		{rst_b, hsel, hwrite, pwm_odd, htrans, ev, lvl} = '0;
		ce = 1'b1;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		for (i = 0; i < 24; i += 4)
			rdc(8'(i), 32'h00000000, "reset value");
		wr(8'h18, 32'hFFFFFFFF);
		rdc(8'h18, 32'h00000000, "unmapped");
		for (s = 0; s < 2; s++)
		begin
			wr(ADDR_CTRL_A, 32'(s));
			for (i = 0; i < 64; i++)
			begin
				wr(ADDR_CONFIG, 32'h2000 | 32'(i[4:0]));
				pwm_odd <= i[5];
				repeat (2) @(negedge mclk);
				chk("bemf", 32'(ok_exp(s[0], i[5:0])), 32'(bemf));
				chk("os_eff", s ? 32'(i[1:0]) : 32'(i[2:0]), 32'(os_eff));
				chk("min_off", s ? 32'h139 : 32'h72, 32'(moff));
				@(posedge mclk);
			end
		end
		wr(ADDR_CTRL_A, 32'h1);
		lvl <= 4'h2;
		wr(ADDR_PHASE, 32'h0);
		repeat (700) @(posedge mclk);
		rdc(ADDR_MASK, 32'h00, "input a");
		wr(ADDR_PHASE, 32'h1);
		repeat (700) @(posedge mclk);
		rdc(ADDR_MASK, 32'h80, "input b");
		wr(ADDR_CTRL_A, 32'h3);
		lvl <= 4'h0;
		repeat (700) @(posedge mclk);
		rdc(ADDR_MASK, 32'h80, "frozen");
		wr(ADDR_CTRL_A, 32'h1);
		repeat (700) @(posedge mclk);
		wr(ADDR_CTRL_A, 32'h3);
		rdc(ADDR_MASK, 32'h00, "relatched");
		wr(ADDR_CTRL_A, 32'h1);
		lvl <= 4'h4;
		wr(ADDR_PHASE, 32'h2);
		repeat (700) @(posedge mclk);
		rdc(ADDR_MASK, 32'h80, "input c");
		lvl <= 4'h0;
		wr(ADDR_CONFIG, 32'h100);
		wr(ADDR_MASK, 32'h1);
		{bz, bd} = {nz, nd};
		pulse(3'h1);
		pulse(3'h2);
		wait_n(nz, bz + 1);
		chk("sensor demag", 32'(bd), 32'(nd));
		rdc(ADDR_STATUS, 32'h5, "flags");
		chk("irq set", 32'h1, 32'(irq));
		wr(ADDR_STATUS, 32'h7);
		repeat (3) @(posedge mclk);
		chk("irq clear", 32'h0, 32'(irq));
		ce <= 1'b0;
		pulse(3'h1);
		ce <= 1'b1;
		rdc(ADDR_STATUS, 32'h0, "held by ce");
		wr(ADDR_CTRL_A, 32'h0);
		wr(ADDR_CONFIG, 32'h123);
		lvl <= 4'hA;
		repeat (10) @(posedge mclk);
		{bz, bd} = {nz, nd};
		pulse(3'h4);
		pulse(3'h1);
		pulse(3'h2);
		repeat (30) @(posedge mclk);
		chk("early demag", 32'(bd), 32'(nd));
		pulse(3'h2);
		wait_n(nd, bd + 1);
		pulse(3'h4);
		repeat (30) @(posedge mclk);
		chk("early zero", 32'(bz), 32'(nz));
		pulse(3'h4);
		wait_n(nz, bz + 1);
		chk("demag count", 32'(bd + 1), 32'(nd));
		// Hardware demagnetization: comparator low at a tick, then Z on a high level.
		wr(ADDR_STATUS, 32'h7);
		wr(ADDR_MASK, 32'h2);
		wr(ADDR_CONFIG, 32'hA3);
		lvl <= 4'h2;
		repeat (10) @(posedge mclk);
		{bz, bd} = {nz, nd};
		pulse(3'h1);
		wait_n(nd, bd + 1);
		lvl <= 4'hA;
		repeat (30) @(posedge mclk);
		chk("demag irq", 32'h1, 32'(irq));
		pulse(3'h4);
		wait_n(nz, bz + 1);
		rdc(ADDR_STATUS, 32'h7, "all flags");
		results();
	end
endmodule : rotor_position_event_qualifier_tb_top
